// File: hw/pcs_cfg_map.svh
// Offsets, field positions, reset values and fixed words of the PCS
// pin-driven configuration block.
// Assumes inclusion by bare name from design files that need the map.
`ifndef PCS_CFG_MAP_SVH
`define PCS_CFG_MAP_SVH

// Register byte offsets on the AXI4-Lite slave.
`define OFS_CTRL_VIEW     4'h0
`define OFS_ADVERT_WORD   4'h4
`define OFS_MODE_CFG      4'h8
`define OFS_STATUS        4'hC

// Control setting bus bit positions.
`define CTL_UNIDIR        0
`define CTL_LOOPBACK      1
`define CTL_POWER_DOWN    2
`define CTL_ISOLATE       3
`define CTL_AUTONEG_EN    4

// Advertisement word field positions.
`define ADV_SGMII_ONE     0
`define ADV_FULL_DUPLEX   5
`define ADV_PAUSE_HI      8
`define ADV_PAUSE_LO      7
`define ADV_SPEED_HI      11
`define ADV_SPEED_LO      10
`define ADV_RFAULT_HI     13
`define ADV_RFAULT_LO     12
`define ADV_SGMII_DUPLEX  12
`define ADV_ACK           14
`define ADV_LINK_UP       15

// Fixed advertisement word in SGMII MAC mode.
`define ADV_MAC_FIXED     16'h4001

// Reset value of the mode register: 1000BASE-X, MAC side, transceiver.
`define MODE_CFG_RESET    3'h0

// AXI response codes.
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2

`endif

// File: hw/pcs_cfg_pkg.sv
// Types shared by the PCS pin-driven configuration block.
// Assumes the constants live in pcs_cfg_map.svh.
package pcs_cfg_pkg;

  // Control setting bus, one bit per control function.
  typedef struct packed {
    logic autoneg_en;
    logic isolate;
    logic power_down;
    logic loopback;
    logic unidir;
  } ctrl_bits_s;

  // Software mode register contents.
  typedef struct packed {
    logic tbi;
    logic phy_side;
    logic sgmii;
  } mode_cfg_s;

  // Advertisement word type.
  typedef logic [15:0] adv_word_t;

  // Operating standard derived from the mode register.
  typedef enum logic [1:0] {
    MODE_BASEX,
    MODE_SGMII_PHY,
    MODE_SGMII_MAC
  } op_mode_e;

  // Write and read channel states of the bus slave.
  typedef enum logic {
    WR_COLLECT,
    WR_RESPOND
  } wr_state_e;

  typedef enum logic {
    RD_IDLE,
    RD_RESPOND
  } rd_state_e;

endpackage

// File: hw/pcs_pin_config_vectors.sv
// Pin-driven configuration of the PCS control and advertisement words,
// with an AXI4-Lite slave for mode selection and observation.
// Assumes both setting buses come from logic on aclk, so they are used
// without synchroniser stages.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`include "pcs_cfg_map.svh"

module pcs_pin_config_vectors #(
  parameter bit AUTONEG_PRESENT = 1'b1
) (
  // Clock and synchronous active-low reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Setting buses from user logic on aclk.
  input  wire logic [4:0]  control_setting_bus,
  input  wire logic [15:0] advert_setting_bus,
  // Applied control functions towards the PCS and transceiver.
  output logic             unidir_tx_en,
  output logic             internal_loopback,
  output logic             ewrap_request,
  output logic             transceiver_powerdown,
  output logic             gmii_isolate,
  output logic             autoneg_enable,
  // Applied advertisement word towards the autonegotiation function.
  output logic [15:0]      advert_word,
  // AXI4-Lite write address channel.
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Applied control functions, each a flip-flop feeding its port.
  logic                   unidir_reg;
  logic                   loopback_reg;
  logic                   ewrap_reg;
  logic                   powerdown_reg;
  logic                   isolate_reg;
  logic                   autoneg_reg;
  // Last sampled control bus, kept for software observation.
  pcs_cfg_pkg::ctrl_bits_s ctrl_view_reg;
  // Applied advertisement word and its next value.
  pcs_cfg_pkg::adv_word_t advert_word_reg;
  pcs_cfg_pkg::adv_word_t advert_word_next;
  // Mode register written by software.
  pcs_cfg_pkg::mode_cfg_s mode_cfg_reg;
  // Operating standard decoded from the mode register.
  pcs_cfg_pkg::op_mode_e  op_mode;
  // Control bus viewed as its struct.
  pcs_cfg_pkg::ctrl_bits_s ctrl_in;

  // Write channel state and captured address and data.
  pcs_cfg_pkg::wr_state_e wr_state_reg;
  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [31:0]            awaddr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;
  logic                   awready_reg;
  logic                   wready_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   do_write;
  logic                   write_hits_mode;
  logic                   write_hits_any;

  // Read channel state and answer.
  pcs_cfg_pkg::rd_state_e rd_state_reg;
  logic                   arready_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;

  // Returns one when the address names a mapped register. Upper address
  // bits must be zero, so aliases never answer.
  function automatic logic addr_mapped(input logic [31:0] addr);
    logic [3:0] low;
    low = addr[3:0];
    if (addr[31:4] != 28'h0000000) begin
      addr_mapped = 1'b0;
    end else if (low == `OFS_CTRL_VIEW) begin
      addr_mapped = 1'b1;
    end else if (low == `OFS_ADVERT_WORD) begin
      addr_mapped = 1'b1;
    end else if (low == `OFS_MODE_CFG) begin
      addr_mapped = 1'b1;
    end else if (low == `OFS_STATUS) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  endfunction

  // Builds the advertisement word for the current standard. Reserved
  // positions never look at the bus and read as zero.
  function automatic pcs_cfg_pkg::adv_word_t build_advert(
    input pcs_cfg_pkg::op_mode_e   mode,
    input pcs_cfg_pkg::adv_word_t  bus
  );
    pcs_cfg_pkg::adv_word_t w;
    w = 16'h0000;
    case (mode)
      pcs_cfg_pkg::MODE_SGMII_MAC: begin
        // The bus has no effect in MAC mode.
        w = `ADV_MAC_FIXED;
      end
      pcs_cfg_pkg::MODE_SGMII_PHY: begin
        w[`ADV_SGMII_ONE] = 1'b1;
        // Speed code passes as given, including the reserved code.
        w[`ADV_SPEED_HI:`ADV_SPEED_LO] =
          bus[`ADV_SPEED_HI:`ADV_SPEED_LO];
        // Bit 13 stays zero; bit 12 carries duplex.
        w[`ADV_SGMII_DUPLEX] = bus[`ADV_SGMII_DUPLEX];
        w[`ADV_ACK] = bus[`ADV_ACK];
        w[`ADV_LINK_UP] = bus[`ADV_LINK_UP];
      end
      default: begin
        // BASE-X: bit 0 and bits 14 and 15 stay reserved zero.
        w[`ADV_FULL_DUPLEX] = bus[`ADV_FULL_DUPLEX];
        w[`ADV_PAUSE_HI:`ADV_PAUSE_LO] =
          bus[`ADV_PAUSE_HI:`ADV_PAUSE_LO];
        w[`ADV_RFAULT_HI:`ADV_RFAULT_LO] =
          bus[`ADV_RFAULT_HI:`ADV_RFAULT_LO];
      end
    endcase
    build_advert = w;
  endfunction

  // Reads a register word; unmapped offsets return zero.
  function automatic logic [31:0] read_word(input logic [3:0] low);
    logic [31:0] d;
    d = 32'h00000000;
    if (low == `OFS_CTRL_VIEW) begin
      d[4:0] = ctrl_view_reg;
    end else if (low == `OFS_ADVERT_WORD) begin
      d[15:0] = advert_word_reg;
    end else if (low == `OFS_MODE_CFG) begin
      d[2:0] = mode_cfg_reg;
    end else if (low == `OFS_STATUS) begin
      d[0] = powerdown_reg;
      d[1] = loopback_reg;
      d[2] = ewrap_reg;
      d[3] = isolate_reg;
      d[4] = autoneg_reg;
      d[5] = unidir_reg;
      d[7:6] = op_mode;
    end else begin
      d = 32'h00000000;
    end
    read_word = d;
  endfunction

  // The buses come from logic on aclk, so they are taken as they are.
  assign ctrl_in = control_setting_bus;

  // Decode the standard. The PHY-side bit only matters under SGMII.
  always_comb begin
    if (!mode_cfg_reg.sgmii) begin
      op_mode = pcs_cfg_pkg::MODE_BASEX;
    end else if (mode_cfg_reg.phy_side) begin
      op_mode = pcs_cfg_pkg::MODE_SGMII_PHY;
    end else begin
      op_mode = pcs_cfg_pkg::MODE_SGMII_MAC;
    end
  end

  // Next advertisement word from the bus and the current standard.
  always_comb begin
    advert_word_next = build_advert(op_mode, advert_setting_bus);
  end

  // Apply the control bus every cycle; no management path is involved.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unidir_reg    <= 1'b0;
      isolate_reg   <= 1'b0;
      autoneg_reg   <= 1'b0;
      ctrl_view_reg <= '0;
    end else begin
      ctrl_view_reg <= ctrl_in;
      // Transmit regardless of the receive path when set.
      unidir_reg    <= ctrl_in.unidir;
      // Isolation of the client interface follows the bit directly.
      isolate_reg   <= ctrl_in.isolate;
      // Without the function the enable is forced off.
      autoneg_reg   <= ctrl_in.autoneg_en & AUTONEG_PRESENT;
    end
  end

  // Loopback is steered by the attachment: internal with a transceiver,
  // or a wrap request to an external PMA in ten-bit mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loopback_reg <= 1'b0;
      ewrap_reg    <= 1'b0;
    end else if (mode_cfg_reg.tbi) begin
      loopback_reg <= 1'b0;
      ewrap_reg    <= ctrl_in.loopback;
    end else begin
      loopback_reg <= ctrl_in.loopback;
      ewrap_reg    <= 1'b0;
    end
  end

  // Power-down is sticky: once entered, only reset brings the
  // transceiver back, so dropping the bit alone does nothing. In ten-bit
  // mode the bit is ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerdown_reg <= 1'b0;
    end else if (ctrl_in.power_down && !mode_cfg_reg.tbi) begin
      powerdown_reg <= 1'b1;
    end
  end

  // Register the advertisement word so the port comes from a flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      advert_word_reg <= 16'h0000;
    end else begin
      advert_word_reg <= advert_word_next;
    end
  end

  // A write proceeds once both address and data have been captured.
  always_comb begin
    do_write        = (wr_state_reg == pcs_cfg_pkg::WR_COLLECT) &&
                      aw_held_reg && w_held_reg;
    write_hits_any  = addr_mapped(awaddr_reg);
    write_hits_mode = write_hits_any &&
                      (awaddr_reg[3:0] == `OFS_MODE_CFG);
  end

  // Write channel: address and data are taken in either order, then
  // one response is given. Read-only registers accept and drop writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= pcs_cfg_pkg::WR_COLLECT;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 32'h00000000;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `AXI_RESP_OKAY;
    end else begin
      case (wr_state_reg)
        pcs_cfg_pkg::WR_COLLECT: begin
          if (do_write) begin
            // Both halves present: answer and stop taking more.
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            bvalid_reg   <= 1'b1;
            bresp_reg    <= write_hits_any ? `AXI_RESP_OKAY
                                           : `AXI_RESP_SLVERR;
            wr_state_reg <= pcs_cfg_pkg::WR_RESPOND;
          end else begin
            // Capture each half once, then hold its ready low.
            if (s_axi_awvalid && awready_reg) begin
              aw_held_reg <= 1'b1;
              awaddr_reg  <= s_axi_awaddr;
              awready_reg <= 1'b0;
            end else begin
              awready_reg <= !aw_held_reg;
            end
            if (s_axi_wvalid && wready_reg) begin
              w_held_reg <= 1'b1;
              wdata_reg  <= s_axi_wdata;
              wstrb_reg  <= s_axi_wstrb;
              wready_reg <= 1'b0;
            end else begin
              wready_reg <= !w_held_reg;
            end
          end
        end
        pcs_cfg_pkg::WR_RESPOND: begin
          // Readies reopen only after the response has been taken.
          if (s_axi_bready) begin
            bvalid_reg   <= 1'b0;
            awready_reg  <= 1'b1;
            wready_reg   <= 1'b1;
            wr_state_reg <= pcs_cfg_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state_reg <= pcs_cfg_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  // Mode register: only the low byte lane carries fields.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_cfg_reg <= `MODE_CFG_RESET;
    end else if (do_write && write_hits_mode && wstrb_reg[0]) begin
      mode_cfg_reg <= wdata_reg[2:0];
    end
  end

  // Read channel: one outstanding read, answered the cycle after the
  // address is taken. Unmapped reads return zero with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= pcs_cfg_pkg::RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h00000000;
      rresp_reg    <= `AXI_RESP_OKAY;
    end else begin
      case (rd_state_reg)
        pcs_cfg_pkg::RD_IDLE: begin
          if (s_axi_arvalid && arready_reg) begin
            arready_reg  <= 1'b0;
            rvalid_reg   <= 1'b1;
            rdata_reg    <= addr_mapped(s_axi_araddr) ?
                            read_word(s_axi_araddr[3:0]) : 32'h00000000;
            rresp_reg    <= addr_mapped(s_axi_araddr) ? `AXI_RESP_OKAY
                                                      : `AXI_RESP_SLVERR;
            rd_state_reg <= pcs_cfg_pkg::RD_RESPOND;
          end else begin
            arready_reg <= 1'b1;
          end
        end
        pcs_cfg_pkg::RD_RESPOND: begin
          if (s_axi_rready) begin
            rvalid_reg   <= 1'b0;
            arready_reg  <= 1'b1;
            rd_state_reg <= pcs_cfg_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= pcs_cfg_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Ports are wired straight from their flip-flops.
  assign unidir_tx_en          = unidir_reg;
  assign internal_loopback     = loopback_reg;
  assign ewrap_request         = ewrap_reg;
  assign transceiver_powerdown = powerdown_reg;
  assign gmii_isolate          = isolate_reg;
  assign autoneg_enable        = autoneg_reg;
  assign advert_word           = advert_word_reg;
  assign s_axi_awready         = awready_reg;
  assign s_axi_wready          = wready_reg;
  assign s_axi_bresp           = bresp_reg;
  assign s_axi_bvalid          = bvalid_reg;
  assign s_axi_arready         = arready_reg;
  assign s_axi_rdata           = rdata_reg;
  assign s_axi_rresp           = rresp_reg;
  assign s_axi_rvalid          = rvalid_reg;

endmodule

// File: sim/cfg_fabric.sv
// Model of the user fabric that drives the two setting buses.
// Assumes the bench hands it requested values on the same aclk.
module cfg_fabric (
  // Clock shared with the block.
  input  wire logic        aclk,
  // Requested values from the bench.
  input  wire logic [4:0]  ctl_req,
  input  wire logic [15:0] adv_req,
  // Setting buses towards the block.
  output logic      [4:0]  control_setting_bus,
  output logic      [15:0] advert_setting_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  // Registering on aclk keeps both buses synchronous and stable.
  always @(posedge aclk) begin
    control_setting_bus <= ctl_req;
    advert_setting_bus  <= adv_req;
  end
endmodule

// File: sim/pcs_cfg_checker.sv
// Assertions on the ports of the pin configuration block.
// Assumes one clock domain with a synchronous active-low reset.
module pcs_cfg_checker #(
  parameter bit AUTONEG_PRESENT = 1'b1
) (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Setting buses.
  input wire logic [4:0]  control_setting_bus,
  input wire logic [15:0] advert_setting_bus,
  // Applied functions.
  input wire logic        unidir_tx_en,
  input wire logic        internal_loopback,
  input wire logic        ewrap_request,
  input wire logic        transceiver_powerdown,
  input wire logic        gmii_isolate,
  input wire logic        autoneg_enable,
  input wire logic [15:0] advert_word,
  // Bus handshakes.
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Unidir, and the OR of loopback and wrap, mirror the bus bit sampled one edge earlier.
  property p_unidir;
    $past(aresetn) |-> unidir_tx_en == $past(control_setting_bus[0]);
  endproperty
  a_unidir: assert property (p_unidir) else $error("unidir wrong");
  property p_loop;
    $past(aresetn) |-> (internal_loopback | ewrap_request)
      == $past(control_setting_bus[1]);
  endproperty
  a_loop: assert property (p_loop) else $error("loop wrong");
  // Loopback and wrap are routed to one place only.
  property p_excl;
    !(internal_loopback && ewrap_request);
  endproperty
  a_excl: assert property (p_excl) else $error("both loops");
  // Power-down is sticky, and only a set bus bit raises it.
  property p_pd_hold;
    $past(transceiver_powerdown) |-> transceiver_powerdown;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("pd dropped");
  property p_pd_set;
    $rose(transceiver_powerdown) |-> $past(control_setting_bus[2]);
  endproperty
  a_pd_set: assert property (p_pd_set) else $error("pd cause");
  property p_iso;
    $past(aresetn) |-> gmii_isolate == $past(control_setting_bus[3]);
  endproperty
  a_iso: assert property (p_iso) else $error("isolate wrong");
  property p_an;
    $past(aresetn) |->
      autoneg_enable == ($past(control_setting_bus[4]) && AUTONEG_PRESENT);
  endproperty
  a_an: assert property (p_an) else $error("autoneg wrong");
  // Bits 1 to 4, 6 and 9 are reserved in every mode.
  property p_resv;
    (advert_word & 16'h025E) == 16'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  // A clear bit 0 means BASE-X, where only its own fields pass.
  property p_basex;
    $past(aresetn) && !advert_word[0] |->
      advert_word == ($past(advert_setting_bus) & 16'h31A0);
  endproperty
  a_basex: assert property (p_basex) else $error("basex word");
  // A read is answered on the next cycle and blocks a second one.
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rclr;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rclr: assert property (p_rclr) else $error("rvalid stuck");

  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_pd: cover property ($rose(transceiver_powerdown));
endmodule

bind pcs_pin_config_vectors pcs_cfg_checker #(
  .AUTONEG_PRESENT(AUTONEG_PRESENT)
) chk_u (
  .aclk, .aresetn, .control_setting_bus, .advert_setting_bus,
  .unidir_tx_en, .internal_loopback, .ewrap_request,
  .transceiver_powerdown, .gmii_isolate, .autoneg_enable, .advert_word,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rresp
);

// File: sim/tb.sv
// Self-checking bench for the pin configuration block.
// Assumes the fabric model drives the buses and the bench masters AXI.
`include "pcs_cfg_map.svh"
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  ctl_req = 5'h00;
  logic [15:0] adv_req = 16'h0000;
  logic [4:0]  control_setting_bus;
  logic [15:0] advert_setting_bus;
  logic        unidir_tx_en, internal_loopback, ewrap_request;
  logic        transceiver_powerdown, gmii_isolate, autoneg_enable;
  logic [15:0] advert_word;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [31:0] seed = 32'hF2AB;
  logic [33:0] rq[$];           // Expected {rresp, rdata} per read.
  logic [1:0]  wq[$];           // Expected bresp per write.

  always #4 aclk = ~aclk;

  cfg_fabric fab_u (.aclk, .ctl_req, .adv_req, .control_setting_bus,
    .advert_setting_bus);

  pcs_pin_config_vectors #(.AUTONEG_PRESENT(1'b1)) dut_u (
    .aclk, .aresetn, .control_setting_bus, .advert_setting_bus,
    .unidir_tx_en, .internal_loopback, .ewrap_request,
    .transceiver_powerdown, .gmii_isolate, .autoneg_enable, .advert_word,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // Shift register giving repeatable random bus values.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Word the block should apply, from mode bits and bus value.
  function automatic logic [15:0] exp_adv(input logic [2:0] m,
                                          input logic [15:0] b);
    if (!m[0]) return b & 16'h31A0;
    if (m[1]) return 16'h0001 | (b & 16'hDC00);
    return `ADV_MAC_FIXED;
  endfunction

  // One write; each half is released at the edge that takes it.
  // Waits carry no limit of their own: only the watchdog ends a hang.
  task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
    bit ad = 1'b0;
    bit wd = 1'b0;
    wq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // One read; rready stays up until rvalid is seen.
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Compares each bus answer against the oldest queued note.
  always @(posedge aclk) begin
    logic [33:0] n;
    if (s_axi_bvalid && s_axi_bready && wq.size() > 0) begin
      n = {32'h0, wq.pop_front()};
      `CHK("bresp", n[1:0], s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      n = rq.pop_front();
      `CHK("rdata", n, {s_axi_rresp, s_axi_rdata})
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // The tests need well under a thousand cycles per mode.
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("unexpected timeout exp %h got %h", 1'b0, 1'b1);
    stop_test;
  end

  initial begin
    logic [2:0] modes[4];
    logic [2:0] m;
    logic [4:0] c;
    logic [15:0] b;
    logic [1:0] om;
    logic pd_exp;
    modes = '{3'h4, 3'h0, 3'h3, 3'h1}; // Wrap, BASE-X, PHY, MAC.
    pd_exp = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // A live control view makes an aliased unmapped read visible.
    ctl_req <= 5'h1B;
    rd(32'h8, {`AXI_RESP_OKAY, 32'h0});
    rd(32'h10, {`AXI_RESP_SLVERR, 32'h0});
    wr(32'h10, 32'h7, `AXI_RESP_SLVERR);
    wr(32'h0, 32'h1F, `AXI_RESP_OKAY);
    // Without the low byte lane the mode register keeps its value.
    s_axi_wstrb <= 4'hE;
    wr(32'h8, 32'h7, `AXI_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(32'h8, {`AXI_RESP_OKAY, 32'h0});
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      m = modes[k];
      om = !m[0] ? 2'h0 : (m[1] ? 2'h1 : 2'h2);
      wr(32'h8, {29'h0, m}, `AXI_RESP_OKAY);
      rd(32'h8, {`AXI_RESP_OKAY, 29'h0, m});
      for (int i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        c = seed[4:0];
        b = seed[31:16];
        b[8:7] = i[1:0];
        b[11:10] = i[1:0];
        b[13:12] = i[1:0];
        c[2] = c[2] | (k == 0) | (k == 1 && i == 3);
        ctl_req <= c;
        adv_req <= b;
        repeat (3) @(posedge aclk);
        pd_exp = pd_exp | (c[2] & !m[2]);
        `CHK("unidir", c[0], unidir_tx_en)
        `CHK("loopback", c[1] & !m[2], internal_loopback)
        `CHK("ewrap", c[1] & m[2], ewrap_request)
        `CHK("powerdown", pd_exp, transceiver_powerdown)
        `CHK("isolate", c[3], gmii_isolate)
        `CHK("autoneg", c[4], autoneg_enable)
        `CHK("advert", exp_adv(m, b), advert_word)
        rd(32'h4, {`AXI_RESP_OKAY, 16'h0, exp_adv(m, b)});
        rd(32'h0, {`AXI_RESP_OKAY, 27'h0, c});
        rd(32'hC, {`AXI_RESP_OKAY, 24'h0, om, c[0], c[4], c[3],
                   c[1] & m[2], c[1] & !m[2], pd_exp});
      end
      $display("test mode %0d done", m);
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    ctl_req <= 5'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("powerdown", 1'b0, transceiver_powerdown)
    rd(32'h8, {`AXI_RESP_OKAY, 32'h0});
    rd(32'h4, {`AXI_RESP_OKAY, 16'h0, exp_adv(3'h0, b)});
    $display("test second reset done");
    stop_test;
  end
endmodule
